// ---- design/iog_map.svh ----
// register indices, byte addressing, field positions and reset values
`ifndef IOG_MAP_SVH
`define IOG_MAP_SVH

// ----------------------------------------------------------------------
// register indices (byte address is index times word size)
// ----------------------------------------------------------------------
`define IOG_I_OE_TX 12'h100
`define IOG_I_OE_RXA 12'h101
`define IOG_I_OE_CCA 12'h102
`define IOG_I_OE_RXB 12'h103
`define IOG_I_SRC_EN 12'h104
`define IOG_I_SRC_FLAG 12'h110
`define IOG_I_SRC_MASK 12'h111
`define IOG_WORD 12'h004

// ----------------------------------------------------------------------
// values
// ----------------------------------------------------------------------
`define IOG_RST_BYTE 8'h00
`define IOG_RD_ZERO 32'h0000_0000
`define IOG_PAD_ZERO 24'h00_0000
`define IOG_LANE0 2'h0

// ----------------------------------------------------------------------
// source group bit positions
// ----------------------------------------------------------------------
`define IOG_B_CSMA 3'h7
`define IOG_B_SYNC_TX 3'h6
`define IOG_B_TXB 3'h5
`define IOG_B_TXA 3'h4
`define IOG_B_CAL 3'h3
`define IOG_B_TIMC 3'h2
`define IOG_B_TIMB 3'h1
`define IOG_B_TIMA 3'h0

`endif

// ---- design/iog_pkg.sv ----
// shared types of the irq output gating block
package iog_pkg;
    typedef logic [7:0] iog_byte_t;
    typedef enum logic {
        IOG_IDLE = 1'b0,
        IOG_ACCESS = 1'b1
    } iog_apb_st_t;
endpackage

// ---- design/iog_top.sv ----
// irq output gating: output enables, source enables, source flags, apb slave
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`include "iog_map.svh"

module iog_top
    import iog_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic csma_done,
    input wire logic sync_tx_done,
    input wire logic bank_b_tx_done,
    input wire logic bank_a_tx_done,
    input wire logic cal_done,
    input wire logic timer_compare_c,
    input wire logic timer_compare_b,
    input wire logic timer_compare_a,
    input wire logic [7:0] req_tx_grp,
    input wire logic [7:0] req_rx_grp_a,
    input wire logic [7:0] req_cca_grp,
    input wire logic [7:0] req_rx_grp_b,
    output logic irq_output_pin_first
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    iog_apb_st_t st_reg;
    iog_byte_t oe_tx_reg;
    iog_byte_t oe_rxa_reg;
    iog_byte_t oe_cca_reg;
    iog_byte_t oe_rxb_reg;
    iog_byte_t src_en_reg;
    iog_byte_t flag_reg;
    iog_byte_t flag_next;
    iog_byte_t mask_reg;
    iog_byte_t ev_vec;
    iog_byte_t src_set;
    iog_byte_t wdata_byte;
    logic [31:0] rd_next;
    logic err_next;
    logic pin_next;
    logic setup_cyc;
    logic wr_fire;
    logic lane0_on;

    // ------------------------------------------------------------------
    // event vector, one bit per source
    // ------------------------------------------------------------------
    always_comb begin
        ev_vec = `IOG_RST_BYTE;
        ev_vec[`IOG_B_CSMA] = csma_done;
        ev_vec[`IOG_B_SYNC_TX] = sync_tx_done;
        ev_vec[`IOG_B_TXB] = bank_b_tx_done;
        ev_vec[`IOG_B_TXA] = bank_a_tx_done;
        ev_vec[`IOG_B_CAL] = cal_done;
        ev_vec[`IOG_B_TIMC] = timer_compare_c;
        ev_vec[`IOG_B_TIMB] = timer_compare_b;
        ev_vec[`IOG_B_TIMA] = timer_compare_a;
    end

    // ------------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------------
    // one wait-free access phase; response is registered during setup
    assign setup_cyc = psel && !penable && (st_reg == IOG_IDLE);
    assign lane0_on = pstrb[`IOG_LANE0];
    assign wdata_byte = pwdata[7:0];
    // an erroring access never stores anything
    assign wr_fire = psel && penable && pready && pwrite && lane0_on && !pslverr;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= IOG_IDLE;
        end else begin
            case (st_reg)
                IOG_IDLE: begin
                    if (setup_cyc) begin
                        st_reg <= IOG_ACCESS;
                    end
                end
                IOG_ACCESS: begin
                    st_reg <= IOG_IDLE;
                end
                default: begin
                    st_reg <= IOG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_cyc;
        end
    end

    // ------------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------------
    always_comb begin
        rd_next = `IOG_RD_ZERO;
        err_next = 1'b0;
        case (paddr)
            `IOG_I_OE_TX * `IOG_WORD: begin
                rd_next = {`IOG_PAD_ZERO, oe_tx_reg};
            end
            `IOG_I_OE_RXA * `IOG_WORD: begin
                rd_next = {`IOG_PAD_ZERO, oe_rxa_reg};
            end
            `IOG_I_OE_CCA * `IOG_WORD: begin
                rd_next = {`IOG_PAD_ZERO, oe_cca_reg};
            end
            `IOG_I_OE_RXB * `IOG_WORD: begin
                rd_next = {`IOG_PAD_ZERO, oe_rxb_reg};
            end
            `IOG_I_SRC_EN * `IOG_WORD: begin
                rd_next = {`IOG_PAD_ZERO, src_en_reg};
            end
            `IOG_I_SRC_FLAG * `IOG_WORD: begin
                rd_next = {`IOG_PAD_ZERO, flag_reg};
            end
            `IOG_I_SRC_MASK * `IOG_WORD: begin
                rd_next = {`IOG_PAD_ZERO, mask_reg};
            end
            default: begin
                err_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= `IOG_RD_ZERO;
            pslverr <= 1'b0;
        end else if (setup_cyc) begin
            prdata <= pwrite ? `IOG_RD_ZERO : rd_next;
            pslverr <= err_next;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // enable registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oe_tx_reg <= `IOG_RST_BYTE;
            oe_rxa_reg <= `IOG_RST_BYTE;
            oe_cca_reg <= `IOG_RST_BYTE;
            oe_rxb_reg <= `IOG_RST_BYTE;
            src_en_reg <= `IOG_RST_BYTE;
            mask_reg <= `IOG_RST_BYTE;
        end else if (wr_fire) begin
            case (paddr)
                `IOG_I_OE_TX * `IOG_WORD: oe_tx_reg <= wdata_byte;
                `IOG_I_OE_RXA * `IOG_WORD: oe_rxa_reg <= wdata_byte;
                `IOG_I_OE_CCA * `IOG_WORD: oe_cca_reg <= wdata_byte;
                `IOG_I_OE_RXB * `IOG_WORD: oe_rxb_reg <= wdata_byte;
                `IOG_I_SRC_EN * `IOG_WORD: src_en_reg <= wdata_byte;
                `IOG_I_SRC_MASK * `IOG_WORD: mask_reg <= wdata_byte;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // source flags
    // ------------------------------------------------------------------
    // disabled sources are dropped, not remembered for a later enable
    assign src_set = ev_vec & src_en_reg;

    always_comb begin
        flag_next = flag_reg;
        if (wr_fire && (paddr == `IOG_I_SRC_FLAG * `IOG_WORD)) begin
            flag_next = flag_reg & ~wdata_byte;
        end
        // set after clear so a same-cycle event survives
        flag_next = flag_next | src_set;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_reg <= `IOG_RST_BYTE;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // ------------------------------------------------------------------
    // interrupt pin
    // ------------------------------------------------------------------
    always_comb begin
        pin_next = |(flag_reg & mask_reg);
        pin_next = pin_next | (|(req_tx_grp & oe_tx_reg));
        pin_next = pin_next | (|(req_rx_grp_a & oe_rxa_reg));
        pin_next = pin_next | (|(req_cca_grp & oe_cca_reg));
        pin_next = pin_next | (|(req_rx_grp_b & oe_rxb_reg));
    end

    // registered pin, so it lags its cause by one clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_output_pin_first <= 1'b0;
        end else begin
            irq_output_pin_first <= pin_next;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_setup;
        psel && !penable && !pready;
    endsequence

    sequence s_answer;
        pready ##1 !pready;
    endsequence

    chk_apb_one_wait: assert property (@(posedge clk) disable iff (sys_rst)
        s_setup |=> s_answer)
        else $error("apb answer not one cycle after setup");

    chk_unmapped_err: assert property (@(posedge clk) disable iff (sys_rst)
        (setup_cyc && err_next) |=> (pslverr && pready && prdata == `IOG_RD_ZERO))
        else $error("unmapped access not flagged");

    chk_reset_zero: assert property (@(posedge clk)
        sys_rst |-> (oe_tx_reg == `IOG_RST_BYTE && oe_rxa_reg == `IOG_RST_BYTE
            && oe_cca_reg == `IOG_RST_BYTE && oe_rxb_reg == `IOG_RST_BYTE
            && src_en_reg == `IOG_RST_BYTE && !irq_output_pin_first))
        else $error("enables not zero in reset");

    chk_pin_tx_drive: assert property (@(posedge clk) disable iff (sys_rst)
        ((req_tx_grp & oe_tx_reg) != `IOG_RST_BYTE) |=> irq_output_pin_first)
        else $error("enabled tx request did not drive pin");

    chk_pin_rxa_drive: assert property (@(posedge clk) disable iff (sys_rst)
        ((req_rx_grp_a & oe_rxa_reg) != `IOG_RST_BYTE) |=> irq_output_pin_first)
        else $error("enabled first rx request did not drive pin");

    chk_pin_cca_drive: assert property (@(posedge clk) disable iff (sys_rst)
        ((req_cca_grp & oe_cca_reg) != `IOG_RST_BYTE) |=> irq_output_pin_first)
        else $error("enabled channel access request did not drive pin");

    chk_pin_rxb_drive: assert property (@(posedge clk) disable iff (sys_rst)
        ((req_rx_grp_b & oe_rxb_reg) != `IOG_RST_BYTE) |=> irq_output_pin_first)
        else $error("enabled second rx request did not drive pin");

    chk_pin_gated_off: assert property (@(posedge clk) disable iff (sys_rst)
        ((flag_reg & mask_reg) == `IOG_RST_BYTE
            && (req_tx_grp & oe_tx_reg) == `IOG_RST_BYTE
            && (req_rx_grp_a & oe_rxa_reg) == `IOG_RST_BYTE
            && (req_cca_grp & oe_cca_reg) == `IOG_RST_BYTE
            && (req_rx_grp_b & oe_rxb_reg) == `IOG_RST_BYTE)
            |=> !irq_output_pin_first)
        else $error("pin high with nothing enabled and pending");

    chk_flag_mask_pin: assert property (@(posedge clk) disable iff (sys_rst)
        ((flag_reg & mask_reg) != `IOG_RST_BYTE) |=> irq_output_pin_first)
        else $error("unmasked flag did not drive pin");

    chk_flag_gated: assert property (@(posedge clk) disable iff (sys_rst)
        (flag_reg == `IOG_RST_BYTE && (ev_vec & src_en_reg) == `IOG_RST_BYTE)
            |=> flag_reg == `IOG_RST_BYTE)
        else $error("flag set by disabled source");

    chk_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
        (src_set != `IOG_RST_BYTE) |=> ((flag_reg & $past(src_set)) == $past(src_set)))
        else $error("enabled event lost");

    chk_src_en_write: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_fire && paddr == `IOG_I_SRC_EN * `IOG_WORD) |=> src_en_reg == $past(wdata_byte))
        else $error("source enable write not stored");

    // a write without its low lane must leave the enable and mask registers alone
    chk_strb_off_keep: assert property (@(posedge clk) disable iff (sys_rst)
        (psel && penable && pready && pwrite && !lane0_on)
            |=> $stable({oe_tx_reg, oe_rxa_reg, oe_cca_reg, oe_rxb_reg, src_en_reg, mask_reg}))
        else $error("write without low lane changed a register");

    chk_rd_oe_tx: assert property (@(posedge clk) disable iff (sys_rst)
        (setup_cyc && !pwrite && paddr == `IOG_I_OE_TX * `IOG_WORD)
            |=> prdata[7:0] == $past(oe_tx_reg))
        else $error("tx output enable readback wrong");

endmodule

// ---- tb/iog_host_mon.sv ----
// host side model: watches the interrupt pin and counts its rising edges
`timescale 1ns/10ps

module iog_host_mon (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic irq_output_pin_first,
    output int unsigned edge_cnt
);
    logic pin_q;

    // a host sees the level only at its own clock, so only whole-cycle rises count
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_q <= 1'b0;
            edge_cnt <= 0;
        end else begin
            pin_q <= irq_output_pin_first;
            if (irq_output_pin_first && !pin_q) begin
                edge_cnt <= edge_cnt + 1;
            end
        end
    end
endmodule

// ---- tb/test_irq_out0_enable_gating.sv ----
// self-checking bench of the irq output gating block over apb
`timescale 1ns/10ps
`include "iog_map.svh"

module test_irq_out0_enable_gating;
    import iog_pkg::*;
    logic clk = 1'b0;
    logic sys_rst;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] ev = 8'h00;
    logic [7:0] req [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
    logic irq_output_pin_first;
    int unsigned edge_cnt;
    int n_errors = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic err;
    logic [11:0] oe_addr [4];
    logic [11:0] all_addr [7];

    always #12.5 clk = ~clk;

    iog_top uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .csma_done(ev[7]), .sync_tx_done(ev[6]), .bank_b_tx_done(ev[5]),
        .bank_a_tx_done(ev[4]), .cal_done(ev[3]), .timer_compare_c(ev[2]),
        .timer_compare_b(ev[1]), .timer_compare_a(ev[0]),
        .req_tx_grp(req[0]), .req_rx_grp_a(req[1]), .req_cca_grp(req[2]),
        .req_rx_grp_b(req[3]), .irq_output_pin_first(irq_output_pin_first));

    iog_host_mon host (.clk(clk), .sys_rst(sys_rst),
        .irq_output_pin_first(irq_output_pin_first), .edge_cnt(edge_cnt));

    // ----------------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // master holds until pready is seen high, giving up with an error after 50 clocks
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk(32'h0, 32'h1);
    endtask

    task automatic pin_is(input logic exp);
        repeat (3) @(posedge clk);
        chk({31'h0, irq_output_pin_first}, {31'h0, exp});
    endtask

    task automatic do_reset;
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    task automatic finish_test;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        n_errors++;
        finish_test();
    end

    // ----------------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------------
    initial begin
        // a real rising edge, so the async reset acts before the first clock
        sys_rst <= 1'b1;
        oe_addr = '{`IOG_I_OE_TX * `IOG_WORD, `IOG_I_OE_RXA * `IOG_WORD,
            `IOG_I_OE_CCA * `IOG_WORD, `IOG_I_OE_RXB * `IOG_WORD};
        all_addr = '{oe_addr[0], oe_addr[1], oe_addr[2], oe_addr[3],
            `IOG_I_SRC_EN * `IOG_WORD, `IOG_I_SRC_FLAG * `IOG_WORD,
            `IOG_I_SRC_MASK * `IOG_WORD};
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            apb(1'b0, all_addr[k], 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, err}, 32'h0);
        end
        // unmapped place is refused and reads zero
        apb(1'b1, 12'h7fc, 32'h0000_00a5);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h7fc, 32'h0);
        chk(rd, 32'h0);
        // each output enable bit gates only its own request bit
        for (int g = 0; g < 4; g++) begin
            for (int i = 0; i < 8; i++) begin
                req[g] <= 8'h01 << i;
                apb(1'b1, oe_addr[g], {24'h0, 8'hff ^ (8'h01 << i)});
                pin_is(1'b0);
                apb(1'b1, oe_addr[g], {24'h0, 8'h01 << i});
                pin_is(1'b1);
                apb(1'b0, oe_addr[g], 32'h0);
                chk(rd, {24'h0, 8'h01 << i});
            end
            req[g] <= 8'h00;
            apb(1'b1, oe_addr[g], 32'h0);
        end
        // events with source enable off are dropped
        apb(1'b1, all_addr[4], 32'h0);
        ev <= 8'hff;
        @(posedge clk);
        ev <= 8'h00;
        apb(1'b0, all_addr[5], 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, all_addr[4], 32'h0000_005a);
        ev <= 8'hff;
        @(posedge clk);
        ev <= 8'h00;
        apb(1'b0, all_addr[5], 32'h0);
        chk(rd, 32'h0000_005a);
        apb(1'b1, all_addr[6], 32'h0000_0002);
        pin_is(1'b1);
        apb(1'b1, all_addr[5], 32'h0000_0002);
        pin_is(1'b0);
        apb(1'b0, all_addr[5], 32'h0);
        chk(rd, 32'h0000_0058);
        // clear and event in one cycle: the set wins
        ev <= 8'h08;
        apb(1'b1, all_addr[5], 32'h0000_0008);
        ev <= 8'h00;
        apb(1'b0, all_addr[5], 32'h0);
        chk(rd, 32'h0000_0058);
        apb(1'b1, all_addr[5], 32'h0000_0008);
        apb(1'b0, all_addr[5], 32'h0);
        chk(rd, 32'h0000_0050);
        chk(edge_cnt, 32'd33);
        // a second reset in mid-run clears the enables again
        do_reset();
        apb(1'b0, all_addr[4], 32'h0);
        chk(rd, 32'h0);
        // a write with the low lane off stores nothing
        pstrb <= 4'he;
        apb(1'b1, all_addr[4], 32'h0000_00ff);
        pstrb <= 4'hf;
        apb(1'b0, all_addr[4], 32'h0);
        chk(rd, 32'h0);
        finish_test();
    end
endmodule
